// >>> src/ccpm_pkg.sv
// package: register map, field layout, mode codes and state record of the ccp unit
package ccpm_pkg;
   // register indices; the byte address is four times the index
   localparam logic [9:0] IDX_INT_STATUS = 10'h00c;
   localparam logic [9:0] IDX_INT_MASK = 10'h00d;
   localparam logic [9:0] IDX_TMR_LO = 10'h00e;
   localparam logic [9:0] IDX_TMR_HI = 10'h00f;
   localparam logic [9:0] IDX_TMR_CTRL = 10'h010;
   localparam logic [9:0] IDX_PERIOD = 10'h012;
   localparam logic [9:0] IDX_CTRL = 10'h017;
   localparam logic [9:0] IDX_VAL_LO = 10'h018;
   localparam logic [9:0] IDX_VAL_HI = 10'h019;
   // event timer control fields
   localparam int TC_ON = 0;
   localparam int TC_EXT = 1;
   localparam int TC_ASYNC = 2;
   // ccp control fields
   localparam int CC_MODE_LSB = 0;
   localparam int CC_DUTY_LSB = 4;
   // interrupt status / mask bits
   localparam int IS_CCP = 0;
   localparam int IS_OVF = 1;
   localparam int IS_PER = 2;
   // reset values
   localparam logic [7:0] PERIOD_RST = 8'hff;
   localparam logic [15:0] VAL_RST = 16'h0000;
   // mode codes
   localparam logic [3:0] M_OFF = 4'h0;
   localparam logic [3:0] M_CAP_FALL = 4'h4;
   localparam logic [3:0] M_CAP_RISE = 4'h5;
   localparam logic [3:0] M_CAP_4 = 4'h6;
   localparam logic [3:0] M_CAP_16 = 4'h7;
   localparam logic [3:0] M_CMP_SET = 4'h8;
   localparam logic [3:0] M_CMP_CLR = 4'h9;
   localparam logic [3:0] M_CMP_IRQ = 4'ha;
   localparam logic [3:0] M_CMP_SPECIAL = 4'hb;
   localparam logic [1:0] M_PWM_TOP = 2'h3;
   // capture prescale terminal counts
   localparam logic [3:0] PRE_4_LAST = 4'h3;
   localparam logic [3:0] PRE_16_LAST = 4'hf;
   // strap settle time before the pin route is caught
   localparam logic [1:0] BOOT_LAST = 2'h3;

   // two-way pin group
   typedef struct packed {
      logic o;
      logic oe;
   } ccpm_pin_t;

   // whole state of the unit
   typedef struct packed {
      logic [5:0] ctrl;
      logic [15:0] val;
      logic [2:0] tcon;
      logic [15:0] tmr;
      logic [7:0] per;
      logic [9:0] pcnt;
      logic [9:0] duty;
      logic [2:0] sts;
      logic [2:0] msk;
      logic irq;
      logic adc_start;
      logic [3:0] pre;
      logic eq_prev;
      logic ext_s1;
      logic ext_s2;
      logic ext_prev;
      logic cap_s1;
      logic cap_s2;
      logic cap_prev;
      logic cfg_s1;
      logic cfg_s2;
      logic route;
      logic [1:0] boot;
      logic cmp_out;
      ccpm_pin_t pin2;
      ccpm_pin_t pin3;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ccpm_state_t;
endpackage : ccpm_pkg

// >>> src/ccpm_top.sv
// capture/compare/pwm unit with its event timer, period timer and apb registers
`timescale 1ns/100ps

module ccpm_top #(
   parameter int ADDR_W = 12
) (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins and straps from outside
   input wire logic ext_count_clk,
   input wire logic port_b_line_two_i,
   input wire logic port_b_line_three_i,
   input wire logic ccp_pin_route_select,
   // core side levels
   input wire logic core_sleep,
   input wire logic adc_enabled,
   // pin drivers
   output logic port_b_line_two_o,
   output logic port_b_line_two_oe,
   output logic port_b_line_three_o,
   output logic port_b_line_three_oe,
   // events out
   output logic adc_start,
   output logic irq,
   output logic wake
);

   ccpm_pkg::ccpm_state_t s_ff;
   ccpm_pkg::ccpm_state_t nxt_s;

   // capture mode codes are 01xx
   function automatic logic is_cap(input logic [3:0] m);
      is_cap = (m[3:2] == 2'b01);
   endfunction : is_cap

   // compare mode codes are 10xx
   function automatic logic is_cmp(input logic [3:0] m);
      is_cmp = (m[3:2] == 2'b10);
   endfunction : is_cmp

   // pwm mode codes are 11xx
   function automatic logic is_pwm(input logic [3:0] m);
      is_pwm = (m[3:2] == ccpm_pkg::M_PWM_TOP);
   endfunction : is_pwm

   logic [3:0] mode;
   logic [9:0] idx;
   logic wr_en;
   logic rd_en;
   logic tb_ok;
   logic tmr_tick;
   logic ext_rise;
   logic cap_rise;
   logic cap_fall;
   logic cap_edge;
   logic cap_hit;
   logic cmp_hit;
   logic per_end;
   logic cap_in;
   logic [2:0] ev;
   logic [2:0] nxt_sts;
   logic [31:0] rd_val;
   logic rd_hit;

   assign mode = s_ff.ctrl[ccpm_pkg::CC_MODE_LSB +: 4];
   assign idx = paddr[11:2];
   // a write takes effect at the edge where pready is seen high; a read samples its register one edge earlier, while pready is still low
   assign wr_en = psel && penable && s_ff.pready && pwrite;
   assign rd_en = psel && penable && !s_ff.pready && !pwrite;

   // selected pin, already through the two flip-flops
   assign cap_in = s_ff.cap_s2;
   assign ext_rise = s_ff.ext_s2 && !s_ff.ext_prev;
   assign cap_rise = cap_in && !s_ff.cap_prev;
   assign cap_fall = !cap_in && s_ff.cap_prev;

   // timer counts count-clock edges or pclk; only the unsynchronised source runs in sleep
   always_comb
   begin
      tmr_tick = 1'b0;
      if (s_ff.tcon[ccpm_pkg::TC_ON])
      begin
         if (s_ff.tcon[ccpm_pkg::TC_EXT])
            tmr_tick = ext_rise && (!core_sleep || s_ff.tcon[ccpm_pkg::TC_ASYNC]);
         else
            tmr_tick = !core_sleep;
      end
   end

   // an unsynchronised external count is refused as capture/compare base
   assign tb_ok = !(s_ff.tcon[ccpm_pkg::TC_EXT] && s_ff.tcon[ccpm_pkg::TC_ASYNC]);

   // capture edge selection
   always_comb
   begin
      cap_edge = 1'b0;
      cap_hit = 1'b0;
      unique case (mode)
         ccpm_pkg::M_CAP_FALL: cap_edge = cap_fall;
         ccpm_pkg::M_CAP_RISE: cap_edge = cap_rise;
         ccpm_pkg::M_CAP_4: cap_edge = cap_rise;
         ccpm_pkg::M_CAP_16: cap_edge = cap_rise;
         default: cap_edge = 1'b0;
      endcase
      if (cap_edge && tb_ok)
      begin
         unique case (mode)
            ccpm_pkg::M_CAP_4: cap_hit = (s_ff.pre == ccpm_pkg::PRE_4_LAST);
            ccpm_pkg::M_CAP_16: cap_hit = (s_ff.pre == ccpm_pkg::PRE_16_LAST);
            default: cap_hit = 1'b1;
         endcase
      end
   end

   // match is caught once, on the cycle the count first equals the value
   assign cmp_hit = is_cmp(mode) && tb_ok && (s_ff.tmr == s_ff.val) && !s_ff.eq_prev;
   assign per_end = (s_ff.pcnt == {s_ff.per, 2'b11});

   // events that raise sticky status bits
   always_comb
   begin
      ev = 3'b000;
      ev[ccpm_pkg::IS_CCP] = cap_hit || cmp_hit;
      ev[ccpm_pkg::IS_OVF] = tmr_tick && (s_ff.tmr == 16'hffff);
      ev[ccpm_pkg::IS_PER] = is_pwm(mode) && per_end;
   end

   // register read mux; bits above a register's width read as zero
   always_comb
   begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (idx)
         ccpm_pkg::IDX_INT_STATUS: rd_val[2:0] = s_ff.sts;
         ccpm_pkg::IDX_INT_MASK: rd_val[2:0] = s_ff.msk;
         ccpm_pkg::IDX_TMR_LO: rd_val[7:0] = s_ff.tmr[7:0];
         ccpm_pkg::IDX_TMR_HI: rd_val[7:0] = s_ff.tmr[15:8];
         ccpm_pkg::IDX_TMR_CTRL: rd_val[2:0] = s_ff.tcon;
         ccpm_pkg::IDX_PERIOD: rd_val[7:0] = s_ff.per;
         ccpm_pkg::IDX_CTRL: rd_val[5:0] = s_ff.ctrl;
         ccpm_pkg::IDX_VAL_LO: rd_val[7:0] = s_ff.val[7:0];
         ccpm_pkg::IDX_VAL_HI: rd_val[7:0] = s_ff.val[15:8];
         default: rd_hit = 1'b0;
      endcase
   end

   // next state of the whole unit
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.adc_start = 1'b0;

      // pins and strap pass two flip-flops before anything reads them
      nxt_s.ext_s1 = ext_count_clk;
      nxt_s.ext_s2 = s_ff.ext_s1;
      nxt_s.ext_prev = s_ff.ext_s2;
      nxt_s.cap_s1 = s_ff.route ? port_b_line_three_i : port_b_line_two_i;
      nxt_s.cap_s2 = s_ff.cap_s1;
      nxt_s.cap_prev = s_ff.cap_s2;
      nxt_s.cfg_s1 = ccp_pin_route_select;
      nxt_s.cfg_s2 = s_ff.cfg_s1;
      // route is caught once after reset so a strap glitch cannot move the pin later
      if (s_ff.boot != ccpm_pkg::BOOT_LAST)
      begin
         nxt_s.boot = s_ff.boot + 2'd1;
         nxt_s.route = s_ff.cfg_s2;
      end

      // event timer
      if (tmr_tick)
         nxt_s.tmr = s_ff.tmr + 16'd1;
      nxt_s.eq_prev = (s_ff.tmr == s_ff.val);

      // capture: snapshot the count into the value register
      if (cap_edge && tb_ok && !cap_hit && (mode == ccpm_pkg::M_CAP_4 || mode == ccpm_pkg::M_CAP_16))
         nxt_s.pre = s_ff.pre + 4'd1;
      if (cap_hit)
      begin
         nxt_s.val = s_ff.tmr;
         nxt_s.pre = 4'h0;
      end

      // compare actions per mode
      if (cmp_hit)
      begin
         unique case (mode)
            ccpm_pkg::M_CMP_SET: nxt_s.cmp_out = 1'b1;
            ccpm_pkg::M_CMP_CLR: nxt_s.cmp_out = 1'b0;
            ccpm_pkg::M_CMP_IRQ: nxt_s.cmp_out = s_ff.cmp_out;
            default:
            begin
               nxt_s.tmr = 16'h0000;
               nxt_s.adc_start = adc_enabled;
            end
         endcase
      end

      // period timer counts in quarter steps so the duty has ten bits
      if (is_pwm(mode))
      begin
         if (per_end)
         begin
            nxt_s.pcnt = 10'h000;
            nxt_s.duty = {s_ff.val[7:0], s_ff.ctrl[ccpm_pkg::CC_DUTY_LSB +: 2]};
         end
         else
            nxt_s.pcnt = s_ff.pcnt + 10'd1;
      end
      else
         nxt_s.pcnt = 10'h000;

      // register writes; byte writes to a running timer may collide with a tick
      if (wr_en)
      begin
         unique case (idx)
            ccpm_pkg::IDX_INT_MASK: nxt_s.msk = pwdata[2:0];
            ccpm_pkg::IDX_TMR_LO: nxt_s.tmr[7:0] = pwdata[7:0];
            ccpm_pkg::IDX_TMR_HI: nxt_s.tmr[15:8] = pwdata[7:0];
            ccpm_pkg::IDX_TMR_CTRL: nxt_s.tcon = pwdata[2:0];
            ccpm_pkg::IDX_PERIOD: nxt_s.per = pwdata[7:0];
            ccpm_pkg::IDX_VAL_LO: nxt_s.val[7:0] = pwdata[7:0];
            ccpm_pkg::IDX_VAL_HI: nxt_s.val[15:8] = pwdata[7:0];
            ccpm_pkg::IDX_CTRL:
            begin
               nxt_s.ctrl = pwdata[5:0];
               nxt_s.pre = 4'h0;
               if (pwdata[3:0] == ccpm_pkg::M_OFF)
               begin
                  nxt_s.val = ccpm_pkg::VAL_RST;
                  nxt_s.cmp_out = 1'b0;
                  nxt_s.duty = 10'h000;
                  nxt_s.ctrl = 6'h00;
               end
            end
            default: nxt_s.msk = s_ff.msk;
         endcase
      end

      // sticky status: write one clears, a same-cycle event wins
      nxt_sts = s_ff.sts;
      if (wr_en && idx == ccpm_pkg::IDX_INT_STATUS)
         nxt_sts = s_ff.sts & ~pwdata[2:0];
      nxt_s.sts = nxt_sts | ev;
      nxt_s.irq = |(nxt_s.sts & nxt_s.msk);

      // pin drivers: compare and pwm drive the routed pin, capture leaves it as input
      nxt_s.pin2 = '{o: 1'b0, oe: 1'b0};
      nxt_s.pin3 = '{o: 1'b0, oe: 1'b0};
      if (is_cmp(mode) || is_pwm(mode))
      begin
         if (nxt_s.route)
            nxt_s.pin3 = '{o: is_pwm(mode) ? (s_ff.pcnt < s_ff.duty) : nxt_s.cmp_out, oe: 1'b1};
         else
            nxt_s.pin2 = '{o: is_pwm(mode) ? (s_ff.pcnt < s_ff.duty) : nxt_s.cmp_out, oe: 1'b1};
      end

      // apb answer: one wait cycle, then pready for one cycle
      nxt_s.pready = psel && penable && !s_ff.pready;
      nxt_s.pslverr = psel && penable && !s_ff.pready && !rd_hit;
      // read data stands only with pready, so it drops even while psel is still high
      if (rd_en)
         nxt_s.prdata = rd_val;
      else
         nxt_s.prdata = 32'h0000_0000;
   end

   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_ff <= '0;
         s_ff.per <= ccpm_pkg::PERIOD_RST;
      end
      else
         s_ff <= nxt_s;
   end

   // outputs straight from the state flip-flops
   assign prdata = s_ff.prdata;
   assign pready = s_ff.pready;
   assign pslverr = s_ff.pslverr;
   assign port_b_line_two_o = s_ff.pin2.o;
   assign port_b_line_two_oe = s_ff.pin2.oe;
   assign port_b_line_three_o = s_ff.pin3.o;
   assign port_b_line_three_oe = s_ff.pin3.oe;
   assign adc_start = s_ff.adc_start;
   assign irq = s_ff.irq;
   assign wake = s_ff.irq;

endmodule : ccpm_top

// >>> verification/ccpm_props.sv
// checker: port-level timing rules of the ccp unit
`timescale 1ns/100ps
module ccpm_props #(
   parameter int ADDR_W = 12
) (
   // apb side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins, straps and events
   input wire logic ccp_pin_route_select,
   input wire logic adc_enabled,
   input wire logic port_b_line_two_oe,
   input wire logic port_b_line_three_oe,
   input wire logic adc_start,
   input wire logic irq,
   input wire logic wake
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a control write with mode 0000 taken at this edge
   wire logic off_wr = psel && penable && pready && pwrite && pwdata[3:0] == 4'h0
      && paddr[ADDR_W-1:2] == ccpm_pkg::IDX_CTRL;

   answer_timing_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("answer not in second access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   slverr_qualified_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("pslverr without answer or with data");
   read_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside an answer");
   wake_tracks_irq_a: assert property (wake == irq)
      else $error("wake differs from irq");
   conv_pulse_a: assert property (adc_start |-> $past(adc_enabled) ##1 !adc_start)
      else $error("conversion start malformed");
   single_route_a: assert property (!(port_b_line_two_oe && port_b_line_three_oe))
      else $error("both port lines driven");
   route_strap_a: assert property (port_b_line_two_oe |-> !ccp_pin_route_select)
      else $error("line two driven against strap");
   off_releases_a: assert property (off_wr |-> ##[1:3] !(port_b_line_two_oe || port_b_line_three_oe))
      else $error("pin still driven after mode off");

   // main scenarios reached
   cover property (adc_start);
   cover property (off_wr);
   cover property (pslverr);
   cover property (port_b_line_two_oe);
endmodule : ccpm_props

bind ccpm_top ccpm_props #(.ADDR_W(ADDR_W)) u_props (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ccp_pin_route_select,
   .adc_enabled, .port_b_line_two_oe, .port_b_line_three_oe, .adc_start, .irq, .wake);

// >>> verification/ccpm_far_side.sv
// far side model: external count clock and the two port-b pins
`timescale 1ns/100ps
module ccpm_far_side (
   // clock and commands from the bench
   input wire logic pclk,
   input wire logic clk_run,
   input wire logic cap_level,
   // pin drive from the unit
   input wire logic two_o,
   input wire logic two_oe,
   input wire logic three_o,
   input wire logic three_oe,
   // towards the unit
   output logic ext_count_clk,
   output logic two_i,
   output logic three_i
);
   logic [1:0] div_ff = 2'h0;
   // count clock of four pclk periods, parked low when stopped so no stray edge
   always_ff @(posedge pclk)
   begin
      div_ff <= clk_run ? div_ff + 2'h1 : 2'h0;
   end
   assign ext_count_clk = div_ff[1];
   // a driven line reads back the unit, an undriven one the external level
   assign two_i = two_oe ? two_o : cap_level;
   assign three_i = three_oe ? three_o : cap_level;
endmodule : ccpm_far_side

// >>> verification/tb.sv
// testbench: register-level tests of the ccp unit
`timescale 1ns/100ps
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic clk_run = 1'b0;
   logic cap_level = 1'b0;
   logic core_sleep = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, ext_clk, two_i, three_i, two_o, two_oe, three_o, three_oe;
   logic adc_start, irq, wake;
   int fail_count = 0;
   int samples_checked = 0;
   int conv_seen = 0;
   int n;
   int pre [4] = '{1, 0, 7, 31};

   always #5 pclk = ~pclk;
   // strap tied to line two, converter always enabled
   ccpm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_count_clk(ext_clk), .port_b_line_two_i(two_i),
      .port_b_line_three_i(three_i), .ccp_pin_route_select(1'b0), .core_sleep(core_sleep),
      .adc_enabled(1'b1), .port_b_line_two_o(two_o), .port_b_line_two_oe(two_oe),
      .port_b_line_three_o(three_o), .port_b_line_three_oe(three_oe),
      .adc_start(adc_start), .irq(irq), .wake(wake));
   ccpm_far_side far (.pclk(pclk), .clk_run(clk_run), .cap_level(cap_level), .two_o(two_o),
      .two_oe(two_oe), .three_o(three_o), .three_oe(three_oe), .ext_count_clk(ext_clk),
      .two_i(two_i), .three_i(three_i));

   // conversion start pulses seen
   always @(posedge pclk)
   begin
      if (adc_start === 1'b1)
         conv_seen++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // one apb transfer; the request stands until pready is sampled high
   task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      check(k < 20, 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d);
   endtask : wr

   task automatic rc(input logic [9:0] idx, input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00);
      check(rd, {24'h0, exp});
   endtask : rc

   task automatic wait_irq(input int lim);
      n = 0;
      while (irq !== 1'b1 && n < lim)
      begin
         @(posedge pclk);
         n++;
      end
      check({31'h0, irq}, 32'h1);
   endtask : wait_irq

   task automatic toggle(input int t);
      repeat (t)
      begin
         cap_level <= ~cap_level;
         repeat (8) @(posedge pclk);
      end
   endtask : toggle

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude

   // watchdog: tests need under a sixth of this span
   initial
   begin
      #300us;
      fail_count++;
      conclude();
   end

   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rc(ccpm_pkg::IDX_PERIOD, 8'hff);
      rc(ccpm_pkg::IDX_CTRL, 8'h00);
      rc(10'h3f0, 8'h00);
      wr(ccpm_pkg::IDX_VAL_LO, 8'h5a);
      wr(ccpm_pkg::IDX_VAL_HI, 8'ha5);
      rc(ccpm_pkg::IDX_VAL_LO, 8'h5a);
      rc(ccpm_pkg::IDX_VAL_HI, 8'ha5);
      $display("registers test done");
      // compare modes in an order that makes each pin action visible
      wr(ccpm_pkg::IDX_INT_MASK, 8'h01);
      wr(ccpm_pkg::IDX_VAL_LO, 8'h00);
      wr(ccpm_pkg::IDX_VAL_HI, 8'h03);
      foreach (pre[i])
      begin
         wr(ccpm_pkg::IDX_TMR_CTRL, 8'h00);
         wr(ccpm_pkg::IDX_TMR_LO, 8'h00);
         wr(ccpm_pkg::IDX_TMR_HI, 8'h00);
         wr(ccpm_pkg::IDX_CTRL, i == 0 ? 8'h08 : i == 1 ? 8'h0a : i == 2 ? 8'h09 : 8'h0b);
         wr(ccpm_pkg::IDX_INT_STATUS, 8'h07);
         conv_seen = 0;
         wr(ccpm_pkg::IDX_TMR_CTRL, 8'h01);
         wait_irq(900);
         repeat (2) @(posedge pclk);
         check({two_oe, two_o}, {1'b1, i < 2});
         check(conv_seen, i == 3);
         rc(ccpm_pkg::IDX_TMR_HI, i == 3 ? 8'h00 : 8'h03);
      end
      wr(ccpm_pkg::IDX_INT_MASK, 8'h00);
      check({31'h0, irq}, 32'h0);
      wr(ccpm_pkg::IDX_INT_MASK, 8'h01);
      check({31'h0, irq}, 32'h1);
      $display("compare test done");
      // capture: one edge short, then the capturing edge
      foreach (pre[i])
      begin
         wr(ccpm_pkg::IDX_CTRL, 8'h04 + 8'(i));
         wr(ccpm_pkg::IDX_INT_STATUS, 8'h07);
         toggle(pre[i]);
         rc(ccpm_pkg::IDX_INT_STATUS, 8'h00);
         toggle(1);
         rc(ccpm_pkg::IDX_INT_STATUS, 8'h01);
      end
      $display("capture test done");
      // pwm with the event timer stopped: duty ten of sixteen counts
      wr(ccpm_pkg::IDX_TMR_CTRL, 8'h00);
      wr(ccpm_pkg::IDX_PERIOD, 8'h03);
      wr(ccpm_pkg::IDX_VAL_LO, 8'h02);
      wr(ccpm_pkg::IDX_CTRL, 8'h2c);
      repeat (40) @(posedge pclk);
      n = 0;
      repeat (160)
      begin
         @(posedge pclk);
         n += (two_o === 1'b1);
      end
      check(n, 100);
      wr(ccpm_pkg::IDX_CTRL, 8'h00);
      rc(ccpm_pkg::IDX_VAL_LO, 8'h00);
      check({two_oe, three_oe}, 2'h0);
      $display("pwm test done");
      // external count clock through sleep, synchronised then free
      wr(ccpm_pkg::IDX_TMR_LO, 8'hf0);
      wr(ccpm_pkg::IDX_TMR_HI, 8'hff);
      wr(ccpm_pkg::IDX_INT_MASK, 8'h02);
      wr(ccpm_pkg::IDX_INT_STATUS, 8'h07);
      core_sleep <= 1'b1;
      clk_run <= 1'b1;
      wr(ccpm_pkg::IDX_TMR_CTRL, 8'h03);
      repeat (100) @(posedge pclk);
      rc(ccpm_pkg::IDX_TMR_LO, 8'hf0);
      wr(ccpm_pkg::IDX_TMR_CTRL, 8'h07);
      wait_irq(400);
      rc(ccpm_pkg::IDX_TMR_HI, 8'h00);
      xfer(1'b0, ccpm_pkg::IDX_TMR_LO, 8'h00);
      rc(ccpm_pkg::IDX_TMR_HI, 8'h00);
      clk_run <= 1'b0;
      core_sleep <= 1'b0;
      $display("timer test done");
      conclude();
   end
endmodule : tb
